/* cam_pkg.sv */
// constants, codes and types shared by the addressing unit
// Function
// - direct mode uses instruction address byte
// - indirect mode addresses via selected pointer register
// - access at old pointer, then modify
// - immediate operand fetched after the opcode
// - short load: low nibble set, high cleared
// - table read addresses via accumulator, pc restored
// - pc two bytes, fifteen address bits used
// - relative jump six bits, -31 to +32
// - page jump loads twelve bits, keeps three
// - long jump loads all fifteen pc bits
// - table jump replaces pc low byte only
// - set, clear, test any data bit
// - pointers and stack in register block F0-FF
package cam_pkg;
	// operation codes presented by the instruction decoder
	localparam logic [3:0] OP_NOP                  = 4'h0;
	localparam logic [3:0] OP_LOAD_DIRECT          = 4'h1;
	localparam logic [3:0] OP_STORE_DIRECT         = 4'h2;
	localparam logic [3:0] OP_LOAD_INDIRECT        = 4'h3;
	localparam logic [3:0] OP_STORE_INDIRECT       = 4'h4;
	localparam logic [3:0] OP_LOAD_IMMEDIATE       = 4'h5;
	localparam logic [3:0] OP_LOAD_PTR_B_SHORT     = 4'h6;
	localparam logic [3:0] OP_LOAD_ACC_FROM_PROGRAM_TABLE = 4'h7;
	localparam logic [3:0] OP_JUMP_SHORT_RELATIVE  = 4'h8;
	localparam logic [3:0] OP_JUMP_PAGE_ABSOLUTE   = 4'h9;
	localparam logic [3:0] OP_JUMP_LONG_ABSOLUTE   = 4'hA;
	localparam logic [3:0] OP_JUMP_THROUGH_TABLE   = 4'hB;
	localparam logic [3:0] OP_BIT_DIRECT           = 4'hC;
	localparam logic [3:0] OP_BIT_INDIRECT         = 4'hD;
	// post-modify selections for indirect accesses
	localparam logic [1:0] POST_NONE = 2'h0;
	localparam logic [1:0] POST_INC  = 2'h1;
	localparam logic [1:0] POST_DEC  = 2'h2;
	// bit operation selections
	localparam logic [1:0] BITOP_SET   = 2'h0;
	localparam logic [1:0] BITOP_CLEAR = 2'h1;
	localparam logic [1:0] BITOP_TEST  = 2'h2;
	// register memory block and the slots inside it
	localparam logic [7:0] REG_BASE     = 8'hF0;
	localparam logic [3:0] SLOT_PTR_X   = 4'hC;
	localparam logic [3:0] SLOT_STACK   = 4'hD;
	localparam logic [3:0] SLOT_PTR_B   = 4'hE;
	localparam logic [7:0] REG_RESET    = 8'h00;
	// program counter layout and reset
	localparam int         PC_WIDTH     = 15;
	localparam logic [14:0] PC_RESET    = 15'h0000;
	localparam int         PAGE_LSB     = 12;
	localparam int         DISP_WIDTH   = 6;
	localparam logic [14:0] LEN_ONE     = 15'h0001;
	localparam logic [14:0] LEN_TWO     = 15'h0002;
	localparam int         PMEM_DEPTH   = 32768;
	localparam int         RAM_DEPTH    = 240;
	// sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_FETCH   = 3'b010,
		ST_POSTMOD = 3'b100
	} cam_state_type;
endpackage : cam_pkg

/* cam_ptr_step.sv */
// pointer post-increment / post-decrement step
`timescale 1ns/1ns
module cam_ptr_step (
	input  wire logic [7:0] ptr_i,  // current pointer value
	input  wire logic       dec_i,  // high: step down, low: step up
	output logic      [7:0] next_o  // stepped pointer value
);
	// an eight-bit sum drops the carry, so 8'hFF+1 gives 8'h00
	// wrap modulo 256
	always_comb begin
		if (dec_i) begin
			next_o = ptr_i - 8'h01;
		end else begin
			next_o = ptr_i + 8'h01;
		end
	end
endmodule : cam_ptr_step

/* cam_addr_unit.sv */
// operand and transfer-of-control addressing unit of the core
`timescale 1ns/1ns
module cam_addr_unit (
	input  wire logic        ref_clk_i,      // core clock
	input  wire logic        rstn_i,         // async reset, active low
	input  wire logic        cmd_valid_i,    // decoded instruction present
	input  wire logic [3:0]  cmd_op_i,       // operation code
	input  wire logic [7:0]  cmd_addr_i,     // direct address byte
	input  wire logic        cmd_ptr_sel_i,  // 0: pointer b, 1: x
	input  wire logic [1:0]  cmd_post_i,     // post-modify selection
	input  wire logic [14:0] cmd_field_i,    // immediate / jump field
	input  wire logic [2:0]  cmd_bit_i,      // bit number
	input  wire logic [1:0]  cmd_bitop_i,    // set, clear or test
	input  wire logic        pmem_we_i,      // program memory load
	input  wire logic [14:0] pmem_waddr_i,   // program memory address
	input  wire logic [7:0]  pmem_wdata_i,   // program memory byte
	output logic             cmd_ready_o,    // unit idle, takes command
	output logic             done_o,         // one-cycle completion
	output logic             bit_test_o,     // last tested bit value
	output logic      [7:0]  acc_o,          // accumulator
	output logic      [7:0]  progcount_high_byte_o, // pc upper byte
	output logic      [7:0]  progcount_low_byte_o,  // pc lower byte
	output logic      [7:0]  ptr_b_o,        // pointer register b
	output logic      [7:0]  ptr_x_o,        // pointer register x
	output logic      [7:0]  stack_pointer_reg_o,   // stack pointer
	output logic      [7:0]  dmem_addr_o     // last effective address
);
	logic [7:0]  pmem [0:cam_pkg::PMEM_DEPTH-1]; // program memory
	logic [7:0]  ram [0:cam_pkg::RAM_DEPTH-1];   // data ram below F0
	logic [7:0]  regfile [0:15];                 // register block
	cam_pkg::cam_state_type state;               // sequencer state
	logic [14:0] pc;            // program counter
	logic [7:0]  acc;           // accumulator
	logic [7:0]  pmem_q;        // registered program memory byte
	logic [3:0]  op_q;          // operation held across steps
	logic        pm_sel;        // pointer to modify, 0: b
	logic        pm_dec;        // modify direction
	logic        done;          // completion pulse
	logic        bit_test;      // tested bit
	logic [7:0]  eff_addr;      // last effective data address
	logic        accept;        // command taken this edge
	logic        is_ind;        // operation addresses via pointer
	logic        has_post;      // indirect load/store with modify
	logic        is_fetch;      // operation reads program memory
	logic [7:0]  ptr_b;         // pointer b contents
	logic [7:0]  ptr_x;         // pointer x contents
	logic [7:0]  ea;            // effective data address
	logic [7:0]  rd_data;       // data read at effective address
	logic [7:0]  mod_data;      // byte after bit set / clear
	logic        wr_en;         // data memory write
	logic [7:0]  wr_data;       // data memory write byte
	logic [14:0] disp;          // relative displacement
	logic [14:0] fetch_addr;    // program memory read address
	logic [14:0] next_pc;       // pc after an accepted command
	logic [7:0]  step_val;      // stepped pointer
	logic [3:0]  pm_slot;       // slot of pointer being modified

	// handshake and operation classes
	assign accept      = cmd_valid_i && (state == cam_pkg::ST_IDLE);
	assign cmd_ready_o = (state == cam_pkg::ST_IDLE);
	assign is_ind   = (cmd_op_i == cam_pkg::OP_LOAD_INDIRECT) ||
	                  (cmd_op_i == cam_pkg::OP_STORE_INDIRECT) ||
	                  (cmd_op_i == cam_pkg::OP_BIT_INDIRECT);
	assign has_post = ((cmd_op_i == cam_pkg::OP_LOAD_INDIRECT) ||
	                   (cmd_op_i == cam_pkg::OP_STORE_INDIRECT)) &&
	                  (cmd_post_i != cam_pkg::POST_NONE);
	assign is_fetch = (cmd_op_i == cam_pkg::OP_LOAD_IMMEDIATE) ||
	    (cmd_op_i == cam_pkg::OP_LOAD_ACC_FROM_PROGRAM_TABLE) ||
	    (cmd_op_i == cam_pkg::OP_JUMP_THROUGH_TABLE);

	assign ptr_b = regfile[cam_pkg::SLOT_PTR_B];
	assign ptr_x = regfile[cam_pkg::SLOT_PTR_X];

	assign ea = is_ind ? (cmd_ptr_sel_i ? ptr_x : ptr_b) : cmd_addr_i;

	// register block answers from F0 up, ram below
	assign rd_data = (ea >= cam_pkg::REG_BASE) ? regfile[ea[3:0]] :
	                 ram[ea];

	always_comb begin
		mod_data = rd_data;
		if (cmd_bitop_i == cam_pkg::BITOP_SET) begin
			mod_data[cmd_bit_i] = 1'b1;
		end else begin
			mod_data[cmd_bit_i] = 1'b0;
		end
	end

	// write strobe: stores, and bit ops other than test
	always_comb begin
		wr_en   = 1'b0;
		wr_data = acc;
		if (accept) begin
			if ((cmd_op_i == cam_pkg::OP_STORE_DIRECT) ||
			    (cmd_op_i == cam_pkg::OP_STORE_INDIRECT)) begin
				wr_en = 1'b1;
			end else if (((cmd_op_i == cam_pkg::OP_BIT_DIRECT) ||
			    (cmd_op_i == cam_pkg::OP_BIT_INDIRECT)) &&
			    (cmd_bitop_i != cam_pkg::BITOP_TEST)) begin
				wr_en   = 1'b1;
				wr_data = mod_data;
			end
		end
	end

	assign disp = {{(cam_pkg::PC_WIDTH-cam_pkg::DISP_WIDTH)
	               {cmd_field_i[5]}}, cmd_field_i[5:0]} + cam_pkg::LEN_ONE;

	// table address from accumulator
	// pc itself is not disturbed, so restoring the low byte is implicit
	assign fetch_addr = (cmd_op_i == cam_pkg::OP_LOAD_IMMEDIATE) ?
	                    (pc + cam_pkg::LEN_ONE) : {pc[14:8], acc};

	// pc after an accepted command; fetch ops finish in ST_FETCH
	always_comb begin
		next_pc = pc + cam_pkg::LEN_ONE;
		unique case (cmd_op_i)
			cam_pkg::OP_LOAD_DIRECT, cam_pkg::OP_STORE_DIRECT,
			cam_pkg::OP_BIT_DIRECT: begin
				next_pc = pc + cam_pkg::LEN_TWO;
			end
			cam_pkg::OP_LOAD_IMMEDIATE,
			cam_pkg::OP_LOAD_ACC_FROM_PROGRAM_TABLE,
			cam_pkg::OP_JUMP_THROUGH_TABLE: begin
				next_pc = pc;
			end
			cam_pkg::OP_JUMP_SHORT_RELATIVE: begin
				next_pc = pc + disp;
			end
			cam_pkg::OP_JUMP_PAGE_ABSOLUTE: begin
				next_pc = {pc[14:cam_pkg::PAGE_LSB], cmd_field_i[11:0]};
			end
			cam_pkg::OP_JUMP_LONG_ABSOLUTE: begin
				next_pc = cmd_field_i;
			end
			default: begin
				next_pc = pc + cam_pkg::LEN_ONE;
			end
		endcase
	end

	// pointer stepper for the post-modify step
	assign pm_slot = pm_sel ? cam_pkg::SLOT_PTR_X : cam_pkg::SLOT_PTR_B;
	cam_ptr_step u_step (
		.ptr_i  (regfile[pm_slot]),
		.dec_i  (pm_dec),
		.next_o (step_val)
	);

	// sequencer
	// modify one cycle after access
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= cam_pkg::ST_IDLE;
		end else begin
			unique case (state)
				cam_pkg::ST_IDLE: begin
					if (accept && is_fetch) begin
						state <= cam_pkg::ST_FETCH;
					end else if (accept && has_post) begin
						state <= cam_pkg::ST_POSTMOD;
					end
				end
				cam_pkg::ST_FETCH, cam_pkg::ST_POSTMOD: begin
					state <= cam_pkg::ST_IDLE;
				end
				default: begin
					state <= cam_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// command context held for the second step
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			op_q   <= cam_pkg::OP_NOP;
			pm_sel <= 1'b0;
			pm_dec <= 1'b0;
		end else if (accept) begin
			op_q   <= cmd_op_i;
			pm_sel <= cmd_ptr_sel_i;
			pm_dec <= (cmd_post_i == cam_pkg::POST_DEC);
		end
	end

	// register block: writes, short load, post-modify
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < 16; i++) begin
				regfile[i] <= cam_pkg::REG_RESET;
			end
		end else if (state == cam_pkg::ST_POSTMOD) begin
			regfile[pm_slot] <= step_val;
		end else if (accept &&
		             cmd_op_i == cam_pkg::OP_LOAD_PTR_B_SHORT) begin
			regfile[cam_pkg::SLOT_PTR_B] <= {4'h0, cmd_field_i[3:0]};
		end else if (wr_en && ea >= cam_pkg::REG_BASE) begin
			regfile[ea[3:0]] <= wr_data;
		end
	end

	// data ram below the register block; no reset, it is storage
	always_ff @(posedge ref_clk_i) begin
		if (wr_en && ea < cam_pkg::REG_BASE) begin
			ram[ea] <= wr_data;
		end
	end

	// program memory load port
	always_ff @(posedge ref_clk_i) begin
		if (pmem_we_i) begin
			pmem[pmem_waddr_i] <= pmem_wdata_i;
		end
	end

	// synchronous program memory read, one cycle of latency
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pmem_q <= 8'h00;
		end else if (accept && is_fetch) begin
			pmem_q <= pmem[fetch_addr];
		end
	end

	// accumulator
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acc <= 8'h00;
		end else if (accept && (cmd_op_i == cam_pkg::OP_LOAD_DIRECT ||
		             cmd_op_i == cam_pkg::OP_LOAD_INDIRECT)) begin
			acc <= rd_data;
		end else if (state == cam_pkg::ST_FETCH &&
		             op_q != cam_pkg::OP_JUMP_THROUGH_TABLE) begin
			acc <= pmem_q;
		end
	end

	// program counter
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pc <= cam_pkg::PC_RESET;
		end else if (accept) begin
			pc <= next_pc;
		end else if (state == cam_pkg::ST_FETCH) begin
			unique case (op_q)
				cam_pkg::OP_LOAD_IMMEDIATE: begin
					pc <= pc + cam_pkg::LEN_TWO;
				end
				cam_pkg::OP_JUMP_THROUGH_TABLE: begin
					pc <= {pc[14:8], pmem_q};
				end
				default: begin
					pc <= pc + cam_pkg::LEN_ONE;
				end
			endcase
		end
	end

	// completion pulse, bit test result, effective address
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			done     <= 1'b0;
			bit_test <= 1'b0;
			eff_addr <= 8'h00;
		end else begin
			done <= (accept && !is_fetch && !has_post) ||
			        (state == cam_pkg::ST_FETCH) ||
			        (state == cam_pkg::ST_POSTMOD);
			if (accept && cmd_bitop_i == cam_pkg::BITOP_TEST &&
			    (cmd_op_i == cam_pkg::OP_BIT_DIRECT ||
			     cmd_op_i == cam_pkg::OP_BIT_INDIRECT)) begin
				bit_test <= rd_data[cmd_bit_i];
			end
			if (accept) begin
				eff_addr <= ea;
			end
		end
	end

	// outputs
	// top pc bit unused
	assign progcount_high_byte_o = {1'b0, pc[14:8]};
	assign progcount_low_byte_o  = pc[7:0];
	assign acc_o               = acc;
	assign ptr_b_o             = ptr_b;
	assign ptr_x_o             = ptr_x;
	assign stack_pointer_reg_o = regfile[cam_pkg::SLOT_STACK];
	assign done_o              = done;
	assign bit_test_o          = bit_test;
	assign dmem_addr_o         = eff_addr;

	// assertions
	sequence s_take(logic [3:0] op);
		accept && cmd_op_i == op;
	endsequence
	sequence s_post_inc;
		accept && has_post && cmd_post_i == cam_pkg::POST_INC;
	endsequence

	a_direct_load: assert property (@(posedge ref_clk_i)
		disable iff (!rstn_i) s_take(cam_pkg::OP_LOAD_DIRECT) |=>
		acc == $past(rd_data) && dmem_addr_o == $past(cmd_addr_i))
		else $error("direct load wrong");
	a_post_order: assert property (@(posedge ref_clk_i)
		disable iff (!rstn_i) s_post_inc ##0 (!cmd_ptr_sel_i) |=>
		(ptr_b == $past(ptr_b)) ##1 (ptr_b == $past(ptr_b, 2) + 8'h01))
		else $error("post increment order wrong");
	a_short_load: assert property (@(posedge ref_clk_i)
		disable iff (!rstn_i) s_take(cam_pkg::OP_LOAD_PTR_B_SHORT) |=>
		ptr_b == {4'h0, $past(cmd_field_i[3:0])})
		else $error("short pointer load wrong");
	a_table_read: assert property (@(posedge ref_clk_i)
		disable iff (!rstn_i)
		s_take(cam_pkg::OP_LOAD_ACC_FROM_PROGRAM_TABLE) |->
		##2 (pc == $past(pc, 2) + cam_pkg::LEN_ONE) && done_o)
		else $error("table read pc not restored");
	a_pc_top: assert property (@(posedge ref_clk_i)
		disable iff (!rstn_i) progcount_high_byte_o[7] == 1'b0)
		else $error("pc top bit set");
	a_rel_jump: assert property (@(posedge ref_clk_i)
		disable iff (!rstn_i) s_take(cam_pkg::OP_JUMP_SHORT_RELATIVE) |=>
		pc == $past(pc) + $past(disp))
		else $error("relative jump target wrong");
	a_page_jump: assert property (@(posedge ref_clk_i)
		disable iff (!rstn_i) s_take(cam_pkg::OP_JUMP_PAGE_ABSOLUTE) |=>
		pc[14:12] == $past(pc[14:12]) &&
		pc[11:0] == $past(cmd_field_i[11:0]))
		else $error("page jump wrong");
	a_long_jump: assert property (@(posedge ref_clk_i)
		disable iff (!rstn_i) s_take(cam_pkg::OP_JUMP_LONG_ABSOLUTE) |=>
		pc == $past(cmd_field_i))
		else $error("long jump wrong");
	a_table_jump: assert property (@(posedge ref_clk_i)
		disable iff (!rstn_i) s_take(cam_pkg::OP_JUMP_THROUGH_TABLE) |->
		##2 (pc[14:8] == $past(pc[14:8], 2)) && done_o)
		else $error("table jump changed high byte");
endmodule : cam_addr_unit

/* cam_pmem_model.sv */
// program memory image loader standing in front of the unit's write port
`timescale 1ns/1ns
module cam_pmem_model #(
	parameter int DLY = 10  // drive delay after the rising edge
) (
	input  wire logic        ref_clk_i,     // core clock
	output logic             pmem_we_o,     // program write strobe
	output logic      [14:0] pmem_waddr_o,  // program write address
	output logic      [7:0]  pmem_wdata_o   // program write byte
);
	// quiet port at time zero
	initial begin
		pmem_we_o    = 1'b0;
		pmem_waddr_o = 15'h0000;
		pmem_wdata_o = 8'h00;
	end

	// one write, entered just after an edge; held for one whole cycle
	task automatic put(input logic [14:0] a, input logic [7:0] d);
		pmem_we_o    = 1'b1;
		pmem_waddr_o = a;
		pmem_wdata_o = d;
		@(posedge ref_clk_i);
		#DLY;
		pmem_we_o    = 1'b0;
		// released lines show the inverse, so a stale value is never reused
		pmem_waddr_o = ~a;
		pmem_wdata_o = ~d;
	endtask : put
endmodule : cam_pmem_model

/* cam_addr_unit_tb.sv */
// self-checking bench for the addressing unit
`timescale 1ns/1ns
module cam_addr_unit_tb;
	localparam int DLY = 10;     // drive delay after the edge
	logic        ref_clk_i;      // core clock
	logic        rstn_i;         // reset, active low
	logic        cmd_valid_i;    // command present
	logic [3:0]  cmd_op_i;       // operation code
	logic [7:0]  cmd_addr_i;     // direct address
	logic        cmd_ptr_sel_i;  // pointer select
	logic [1:0]  cmd_post_i;     // post-modify
	logic [14:0] cmd_field_i;    // immediate or jump field
	logic [2:0]  cmd_bit_i;      // bit number
	logic [1:0]  cmd_bitop_i;    // bit operation
	logic        pmem_we_i;      // program load strobe
	logic [14:0] pmem_waddr_i;   // program load address
	logic [7:0]  pmem_wdata_i;   // program load byte
	logic        cmd_ready_o;    // unit idle
	logic        done_o;         // completion pulse
	logic        bit_test_o;     // tested bit
	logic [7:0]  acc_o;          // accumulator
	logic [7:0]  pc_hi;          // pc upper byte
	logic [7:0]  pc_lo;          // pc lower byte
	logic [7:0]  ptr_b_o;        // pointer b
	logic [7:0]  ptr_x_o;        // pointer x
	logic [7:0]  stack_reg_o;    // stack pointer register
	logic [7:0]  dmem_addr_o;    // last effective address
	logic [14:0] pc;             // expected program counter
	int          num_errors;     // mismatches
	int          n_checks;       // comparisons

	cam_addr_unit uut (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
		.cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
		.cmd_ptr_sel_i(cmd_ptr_sel_i), .cmd_post_i(cmd_post_i),
		.cmd_field_i(cmd_field_i), .cmd_bit_i(cmd_bit_i),
		.cmd_bitop_i(cmd_bitop_i), .pmem_we_i(pmem_we_i),
		.pmem_waddr_i(pmem_waddr_i), .pmem_wdata_i(pmem_wdata_i),
		.cmd_ready_o(cmd_ready_o), .done_o(done_o), .bit_test_o(bit_test_o),
		.acc_o(acc_o), .progcount_high_byte_o(pc_hi),
		.progcount_low_byte_o(pc_lo), .ptr_b_o(ptr_b_o), .ptr_x_o(ptr_x_o),
		.stack_pointer_reg_o(stack_reg_o), .dmem_addr_o(dmem_addr_o));

	cam_pmem_model #(.DLY(DLY)) pmem (
		.ref_clk_i(ref_clk_i), .pmem_we_o(pmem_we_i),
		.pmem_waddr_o(pmem_waddr_i), .pmem_wdata_o(pmem_wdata_i));

	// free-running 10 MHz core clock
	always #50 ref_clk_i = ~ref_clk_i;

	// byte comparison, counted
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
			input string what);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk8

	// pc comparison; the unused top bit must read zero
	task automatic chk_pc();
		n_checks++;
		if ({pc_hi, pc_lo} !== {1'b0, pc}) begin
			num_errors++;
			$display("[FAIL] %0t pc got %h%h exp %h", $time, pc_hi, pc_lo, pc);
		end
	endtask : chk_pc

	// verdict; the one place the run ends
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish

	// one command: held until taken, then wait for done under a bound
	task automatic issue(input logic [3:0] op, input logic [7:0] a,
			input logic [14:0] f);
		int k;
		cmd_op_i    = op;
		cmd_addr_i  = a;
		cmd_field_i = f;
		cmd_valid_i = 1'b1;
		k = 0;
		while (cmd_ready_o !== 1'b1 && k < 8) begin
			@(posedge ref_clk_i);
			#DLY;
			k++;
		end
		@(posedge ref_clk_i);
		#DLY;
		cmd_valid_i = 1'b0;
		while (done_o !== 1'b1 && k < 8) begin
			@(posedge ref_clk_i);
			#DLY;
			k++;
		end
		if (k >= 8) begin
			num_errors++;
			$display("[FAIL] %0t command never completed", $time);
			tally_and_finish();
		end
		// one idle edge, so cmd_valid_i never falls and rises in one step
		@(posedge ref_clk_i);
		#DLY;
	endtask : issue

	// immediate load of the accumulator, operand placed after the opcode
	task automatic imm(input logic [7:0] d);
		pmem.put(pc + 15'h0001, d);
		issue(cam_pkg::OP_LOAD_IMMEDIATE, 8'h00, 15'h0000);
		pc = pc + 15'h0002;
	endtask : imm

	// direct store / load of the accumulator
	task automatic dir(input logic [3:0] op, input logic [7:0] a);
		issue(op, a, 15'h0000);
		pc = pc + 15'h0002;
	endtask : dir

	// indirect access through the selected pointer
	task automatic ind(input logic [3:0] op, input logic s,
			input logic [1:0] p);
		cmd_ptr_sel_i = s;
		cmd_post_i    = p;
		issue(op, 8'h00, 15'h0000);
		pc = pc + 15'h0001;
	endtask : ind

	task automatic t_reset();
		chk8(acc_o, 8'h00, "acc");
		chk8(ptr_b_o, 8'h00, "ptr b");
		chk8(stack_reg_o, 8'h00, "stack");
		chk8({7'h00, cmd_ready_o}, 8'h01, "ready");
		chk_pc();
		$display("reset test done");
	endtask : t_reset

	// far jumps, then operand fetch after the opcode
	task automatic t_jump_imm();
		issue(cam_pkg::OP_JUMP_LONG_ABSOLUTE, 8'h00, 15'h7EF0);
		pc = 15'h7EF0;
		chk_pc();
		issue(cam_pkg::OP_JUMP_LONG_ABSOLUTE, 8'h00, 15'h4123);
		pc = 15'h4123;
		chk_pc();
		imm(8'hA6);
		chk8(acc_o, 8'hA6, "imm acc");
		chk_pc();
		$display("jump and immediate test done");
	endtask : t_jump_imm

	task automatic t_direct();
		dir(cam_pkg::OP_STORE_DIRECT, 8'h05);
		imm(8'h00);
		dir(cam_pkg::OP_LOAD_DIRECT, 8'h05);
		chk8(acc_o, 8'hA6, "direct acc");
		chk8(dmem_addr_o, 8'h05, "direct addr");
		issue(cam_pkg::OP_LOAD_PTR_B_SHORT, 8'h00, 15'h7FF7);
		pc = pc + 15'h0001;
		chk8(ptr_b_o, 8'h07, "short b");
		chk_pc();
		$display("direct and short test done");
	endtask : t_direct

	// pointers placed in the register block, modified after access, wrapped
	task automatic t_pointers();
		imm(8'hFF);
		dir(cam_pkg::OP_STORE_DIRECT, 8'hFE);
		chk8(ptr_b_o, 8'hFF, "b via FE");
		imm(8'h3C);
		dir(cam_pkg::OP_STORE_DIRECT, 8'hFD);
		chk8(stack_reg_o, 8'h3C, "stack via FD");
		ind(cam_pkg::OP_STORE_INDIRECT, 1'b0, cam_pkg::POST_INC);
		chk8(dmem_addr_o, 8'hFF, "inc addr");
		chk8(ptr_b_o, 8'h00, "b wrap");
		imm(8'hC3);
		ind(cam_pkg::OP_STORE_INDIRECT, 1'b1, cam_pkg::POST_DEC);
		chk8(ptr_x_o, 8'hFF, "x wrap");
		ind(cam_pkg::OP_LOAD_INDIRECT, 1'b1, cam_pkg::POST_NONE);
		chk8(acc_o, 8'h3C, "x load");
		chk8(dmem_addr_o, 8'hFF, "x addr");
		dir(cam_pkg::OP_LOAD_DIRECT, 8'h00);
		chk8(acc_o, 8'hC3, "old x");
		chk_pc();
		$display("pointer test done");
	endtask : t_pointers

	// displacement extremes and page jump keeping the three top bits
	task automatic t_rel_page();
		issue(cam_pkg::OP_JUMP_SHORT_RELATIVE, 8'h00, 15'h001F);
		pc = pc + 15'h0020;
		chk_pc();
		issue(cam_pkg::OP_JUMP_SHORT_RELATIVE, 8'h00, 15'h0020);
		pc = pc - 15'h001F;
		chk_pc();
		issue(cam_pkg::OP_JUMP_PAGE_ABSOLUTE, 8'h00, 15'h7A5C);
		pc = {pc[14:12], 12'hA5C};
		chk_pc();
		$display("relative and page test done");
	endtask : t_rel_page

	// table read and table jump through the accumulator
	task automatic t_tables();
		issue(cam_pkg::OP_JUMP_LONG_ABSOLUTE, 8'h00, 15'h2240);
		pc = 15'h2240;
		imm(8'h1F);
		pmem.put({pc[14:8], 8'h1F}, 8'h25);
		issue(cam_pkg::OP_LOAD_ACC_FROM_PROGRAM_TABLE, 8'h00, 15'h0000);
		pc = pc + 15'h0001;
		chk8(acc_o, 8'h25, "table acc");
		chk_pc();
		imm(8'h26);
		pmem.put({pc[14:8], 8'h26}, 8'h32);
		issue(cam_pkg::OP_JUMP_THROUGH_TABLE, 8'h00, 15'h0000);
		pc = {pc[14:8], 8'h32};
		chk_pc();
		chk8(acc_o, 8'h26, "jump acc");
		$display("table test done");
	endtask : t_tables

	// set, test, clear one bit of a data byte
	task automatic t_bits();
		imm(8'h00);
		dir(cam_pkg::OP_STORE_DIRECT, 8'h10);
		cmd_bit_i = 3'h5;
		cmd_bitop_i = cam_pkg::BITOP_SET;
		dir(cam_pkg::OP_BIT_DIRECT, 8'h10);
		cmd_bitop_i = cam_pkg::BITOP_TEST;
		dir(cam_pkg::OP_BIT_DIRECT, 8'h10);
		chk8({7'h00, bit_test_o}, 8'h01, "bit set");
		dir(cam_pkg::OP_LOAD_DIRECT, 8'h10);
		chk8(acc_o, 8'h20, "bit byte");
		cmd_bitop_i = cam_pkg::BITOP_CLEAR;
		dir(cam_pkg::OP_BIT_DIRECT, 8'h10);
		cmd_bitop_i = cam_pkg::BITOP_TEST;
		dir(cam_pkg::OP_BIT_DIRECT, 8'h10);
		chk8({7'h00, bit_test_o}, 8'h00, "bit clear");
		// bit 3 of the same byte, reached through pointer b
		imm(8'h10);
		dir(cam_pkg::OP_STORE_DIRECT, 8'hFE);
		cmd_bit_i = 3'h3;
		cmd_bitop_i = cam_pkg::BITOP_SET;
		ind(cam_pkg::OP_BIT_INDIRECT, 1'b0, cam_pkg::POST_NONE);
		chk8(dmem_addr_o, 8'h10, "bit via b");
		cmd_bitop_i = cam_pkg::BITOP_TEST;
		ind(cam_pkg::OP_BIT_INDIRECT, 1'b0, cam_pkg::POST_NONE);
		chk8({7'h00, bit_test_o}, 8'h01, "bit via b set");
		dir(cam_pkg::OP_LOAD_DIRECT, 8'h10);
		chk8(acc_o, 8'h08, "bit via b byte");
		chk_pc();
		$display("bit test done");
	endtask : t_bits

	// reset again in mid-run: registers leave non-zero values behind
	task automatic t_mid_reset();
		rstn_i = 1'b0;
		repeat (2) @(posedge ref_clk_i);
		#DLY;
		rstn_i = 1'b1;
		pc = 15'h0000;
		t_reset();
	endtask : t_mid_reset

	// main sequence: reset for 16 cycles, then each scenario
	initial begin
		ref_clk_i = 1'b0;
		rstn_i = 1'b0;
		cmd_valid_i = 1'b0;
		cmd_op_i = 4'h0;
		cmd_addr_i = 8'h00;
		cmd_ptr_sel_i = 1'b0;
		cmd_post_i = 2'h0;
		cmd_field_i = 15'h0000;
		cmd_bit_i = 3'h0;
		cmd_bitop_i = 2'h0;
		num_errors = 0;
		n_checks = 0;
		pc = 15'h0000;
		repeat (16) @(posedge ref_clk_i);
		#DLY;
		rstn_i = 1'b1;
		t_reset();
		t_jump_imm();
		t_direct();
		t_pointers();
		t_rel_page();
		t_tables();
		t_bits();
		t_mid_reset();
		tally_and_finish();
	end
endmodule : cam_addr_unit_tb
